/* File: fll_clock_cfg.svh */
// Offsets, reset values and counts of the clock mode controller.
`ifndef FLL_CLOCK_CFG_SVH
`define FLL_CLOCK_CFG_SVH

`define CFG_OFF_CTRL1 4'h0
`define CFG_OFF_CTRL2 4'h4
`define CFG_OFF_TRIM 4'h8
`define CFG_OFF_STATUS 4'hc

`define CFG_CTRL1_RESET 8'h04
`define CFG_CTRL2_RESET 8'h40
`define CFG_TRIM_RESET 8'h80

`define CFG_SRC_FLL 2'h0
`define CFG_SRC_INT 2'h1
`define CFG_SRC_EXT 2'h2
`define CFG_SRC_RSVD 2'h3

`define CFG_STATUS_RSVD_BITS 4'h0
`define CFG_FLL_MULT 512
`define CFG_SWITCH_TICKS 4'h2
`define CFG_RELOCK_TICKS 4'h2
`define CFG_OSC_INIT_TICKS 13'h1000
`define CFG_INT_HALF_BASE 11'h2bc

`endif

/* File: fll_clock_pkg.sv */
// Types shared by the clock mode controller.
package fll_clock_pkg;

    typedef enum logic [2:0] {
        fll_int_mode,
        fll_ext_mode,
        bypass_int_mode,
        bypass_int_lp_mode,
        bypass_ext_mode,
        bypass_ext_lp_mode
    } mode_t;

    typedef enum logic [1:0] {
        sw_idle,
        sw_count,
        sw_handover
    } switch_t;

    typedef struct packed {
        logic [1:0] clock_source_select;
        logic [2:0] ref_divider;
        logic ref_select;
        logic int_ref_enable;
        logic int_ref_stop_en;
    } ctrl1_t;

    typedef struct packed {
        logic [1:0] bus_divider;
        logic freq_range;
        logic high_gain;
        logic low_power_bypass;
        logic ext_osc_request;
        logic ext_ref_enable;
        logic ext_ref_stop_en;
    } ctrl2_t;

    typedef struct packed {
        logic wb_ack;
        logic [31:0] wb_dat;
        ctrl1_t ctrl1;
        ctrl2_t ctrl2;
        logic [7:0] trim_value;
        logic fine_trim;
        logic osc_init_done;
        logic [12:0] osc_cnt;
        logic ext_en_prev;
        logic osc_req_prev;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic int_lvl;
        logic fll_lvl;
        logic refsel_prev;
        logic [6:0] div_cnt;
        logic [19:0] per_cnt;
        logic [19:0] fll_period;
        logic [3:0] lock_cnt;
        logic fll_locked;
        switch_t sw_state;
        logic [1:0] active_src;
        logic [1:0] sw_target;
        logic [3:0] sw_cnt;
        logic [2:0] bus_cnt;
        logic main_clk;
        logic bus_en;
        logic dbg_clk;
        logic int_out;
        logic ext_out;
    } state_t;

endpackage : fll_clock_pkg

/* File: tick_divider.sv */
// Enable-pulse divider that ticks once every half_in cycles while running.
module tick_divider #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Control
    input wire logic run_in,
    input wire logic [W-1:0] half_in,
    // Tick
    output logic tick_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } tdiv_state_t;

    tdiv_state_t s_ff;
    tdiv_state_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        if (!run_in) begin
            nxt_s.cnt = '0;
        end else if (s_ff.cnt >= W'(half_in - 1'b1)) begin
            nxt_s.cnt = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.cnt = W'(s_ff.cnt + 1'b1);
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tick_out = s_ff.tick;

endmodule : tick_divider

/* File: fll_clock_mode_controller.sv */
// Clock generator mode controller with Wishbone registers and glitch-free source switch.
//
// Behaviour
// - Eight-bit trim lengthens period with larger value.
// - Fine trim bit: smallest period step.
// - Status field reports active clock source.
// - Status updates only after switch completes.
// - Oscillator done set after initialisation cycles.
// - Done cleared only by enable/request clear.
// - Select 00, internal reference: FLL internal.
// - FLL locks 512x divided reference; link clock.
// - Select 00, external reference: FLL external.
// - Select 01 without low power: bypass internal.
// - Select 01 low power: FLL off outside debug.
// - Select 10 without low power: bypass external.
// - Select 10 low power: FLL off outside debug.
// - Stop holds the main, bus and link clock outputs static.
// - Internal output runs in stop if enabled.
// - External output runs in stop if enabled.
// - FLL relocks after divided reference cycles.
// - Source switch waits new clock cycles.
// - Dead new source keeps previous clock.
// - Reference divider divides by two to power.
// - Source select codes: FLL, internal, external.
// - Bus divider divides by 1, 2, 4, 8.
//
// The address map and the Wishbone register port were decided locally.
`include "fll_clock_cfg.svh"

module fll_clock_mode_controller
    import fll_clock_pkg::*;
#(
    parameter logic [12:0] OSC_INIT_TICKS = `CFG_OSC_INIT_TICKS,
    parameter logic [10:0] INT_HALF_BASE = `CFG_INT_HALF_BASE
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // System state
    input wire logic stop_in,
    input wire logic debug_mode_active_in,
    // External reference pin
    input wire logic ext_ref_in,
    // Clock outputs as levels and enable pulse
    output logic main_clock_out,
    output logic bus_clk_en_out,
    output logic debug_link_clock_out,
    output logic int_ref_clock_out,
    output logic ext_ref_clock_out
);
    localparam int FLL_SHIFT = $clog2(`CFG_FLL_MULT) + 1;
    localparam state_t STATE_RESET = '{
        ctrl1: ctrl1_t'(`CFG_CTRL1_RESET),
        ctrl2: ctrl2_t'(`CFG_CTRL2_RESET),
        trim_value: `CFG_TRIM_RESET,
        active_src: `CFG_SRC_FLL,
        sw_state: sw_idle,
        default: '0
    };

    state_t s_ff;
    state_t nxt_s;

    logic req;
    logic int_tick;
    logic fll_tick;
    logic int_rise;
    logic ext_rise;
    logic fll_rise;
    logic ref_rise;
    logic int_needed;
    logic ext_needed;
    logic int_run;
    logic ext_in_use;
    logic fll_enabled;
    logic fll_run;
    logic div_tick;
    logic [6:0] div_limit;
    logic [2:0] bus_limit;
    logic [10:0] int_half;
    logic [19:0] fll_half;
    logic [1:0] target;
    mode_t mode;

    // Mode follows the written selection; low power only counts outside debug.
    function automatic mode_t decode_mode(ctrl1_t c1, ctrl2_t c2, logic dbg);
        logic lp;
        lp = c2.low_power_bypass && !dbg;
        if (c1.clock_source_select == `CFG_SRC_INT) begin
            decode_mode = lp ? bypass_int_lp_mode : bypass_int_mode;
        end else if (c1.clock_source_select == `CFG_SRC_EXT) begin
            decode_mode = lp ? bypass_ext_lp_mode : bypass_ext_mode;
        end else if (c1.ref_select) begin
            decode_mode = fll_int_mode;
        end else begin
            decode_mode = fll_ext_mode;
        end
    endfunction : decode_mode

    function automatic logic src_lvl(logic [1:0] src, state_t st);
        if (src == `CFG_SRC_INT) begin
            src_lvl = st.int_lvl;
        end else if (src == `CFG_SRC_EXT) begin
            src_lvl = st.ext_s2;
        end else begin
            src_lvl = st.fll_lvl;
        end
    endfunction : src_lvl

    assign req = wb_cyc_in && wb_stb_in;
    assign mode = decode_mode(s_ff.ctrl1, s_ff.ctrl2, debug_mode_active_in);
    assign target = s_ff.ctrl1.clock_source_select;

    assign int_needed = s_ff.ctrl1.ref_select || s_ff.active_src == `CFG_SRC_INT ||
                        target == `CFG_SRC_INT;
    assign ext_needed = !s_ff.ctrl1.ref_select || s_ff.active_src == `CFG_SRC_EXT ||
                        target == `CFG_SRC_EXT;
    assign int_run = stop_in ? (s_ff.ctrl1.int_ref_enable && s_ff.ctrl1.int_ref_stop_en)
                             : (s_ff.ctrl1.int_ref_enable || int_needed);
    assign ext_in_use = stop_in ? (s_ff.ctrl2.ext_ref_enable && s_ff.ctrl2.ext_ref_stop_en)
                                : (s_ff.ctrl2.ext_ref_enable || ext_needed);
    // The FLL keeps running until the main clock has left it, so a low-power write cannot
    // strand the output on a dead source.
    assign fll_enabled = !(mode == bypass_int_lp_mode || mode == bypass_ext_lp_mode) ||
                         s_ff.active_src == `CFG_SRC_FLL;
    assign fll_run = fll_enabled && s_ff.fll_locked && !stop_in;

    assign int_half = 11'(INT_HALF_BASE + {2'h0, s_ff.trim_value, s_ff.fine_trim});
    assign fll_half = (s_ff.fll_period >> FLL_SHIFT) == 20'h0 ? 20'h1
                                                            : (s_ff.fll_period >> FLL_SHIFT);

    assign int_rise = int_tick && !s_ff.int_lvl;
    assign ext_rise = ext_in_use && s_ff.ext_s2 && !s_ff.ext_s3;
    assign fll_rise = fll_tick && !s_ff.fll_lvl;
    assign ref_rise = s_ff.ctrl1.ref_select ? int_rise : ext_rise;
    assign div_limit = 7'((8'h1 << s_ff.ctrl1.ref_divider) - 8'h1);
    assign div_tick = ref_rise && s_ff.div_cnt >= div_limit;
    assign bus_limit = 3'((4'h1 << s_ff.ctrl2.bus_divider) - 4'h1);

    tick_divider #(
        .W(11)
    ) u_int_osc (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .run_in(int_run),
        .half_in(int_half),
        .tick_out(int_tick)
    );

    tick_divider #(
        .W(20)
    ) u_fll_osc (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .run_in(fll_run),
        .half_in(fll_half),
        .tick_out(fll_tick)
    );

    always_comb begin
        logic tgt_rise;
        logic main_rise;
        logic [7:0] wdata;
        tgt_rise = 1'b0;
        main_rise = 1'b0;
        wdata = wb_dat_in[7:0];
        nxt_s = s_ff;

        // Wishbone: ack one cycle after the strobe, write at the edge that sees ack.
        nxt_s.wb_ack = req && !s_ff.wb_ack;
        if (req && !s_ff.wb_ack && !wb_we_in) begin
            if (wb_adr_in == `CFG_OFF_CTRL1) begin
                nxt_s.wb_dat = {24'h0, s_ff.ctrl1};
            end else if (wb_adr_in == `CFG_OFF_CTRL2) begin
                nxt_s.wb_dat = {24'h0, s_ff.ctrl2};
            end else if (wb_adr_in == `CFG_OFF_TRIM) begin
                nxt_s.wb_dat = {24'h0, s_ff.trim_value};
            end else if (wb_adr_in == `CFG_OFF_STATUS) begin
                nxt_s.wb_dat = {24'h0, `CFG_STATUS_RSVD_BITS, s_ff.active_src,
                                s_ff.osc_init_done, s_ff.fine_trim};
            end else begin
                nxt_s.wb_dat = 32'h0;
            end
        end
        if (req && s_ff.wb_ack && wb_we_in && wb_sel_in[0]) begin
            if (wb_adr_in == `CFG_OFF_CTRL1) begin
                nxt_s.ctrl1 = ctrl1_t'(wdata);
                if (wdata[7:6] == `CFG_SRC_RSVD) begin
                    nxt_s.ctrl1.clock_source_select = `CFG_SRC_FLL;
                end
            end else if (wb_adr_in == `CFG_OFF_CTRL2) begin
                nxt_s.ctrl2 = ctrl2_t'(wdata);
            end else if (wb_adr_in == `CFG_OFF_TRIM) begin
                nxt_s.trim_value = wdata;
            end else if (wb_adr_in == `CFG_OFF_STATUS) begin
                nxt_s.fine_trim = wdata[0];
            end
        end

        // Pin synchroniser; only the second and third stages feed logic.
        nxt_s.ext_s1 = ext_ref_in;
        nxt_s.ext_s2 = s_ff.ext_s1;
        nxt_s.ext_s3 = s_ff.ext_s2;
        if (int_tick) begin
            nxt_s.int_lvl = !s_ff.int_lvl;
        end
        if (fll_tick) begin
            nxt_s.fll_lvl = !s_ff.fll_lvl;
        end

        // Oscillator initialisation: a falling enable or request clears, counting sets.
        nxt_s.ext_en_prev = s_ff.ctrl2.ext_ref_enable;
        nxt_s.osc_req_prev = s_ff.ctrl2.ext_osc_request;
        if ((s_ff.ext_en_prev && !s_ff.ctrl2.ext_ref_enable) ||
            (s_ff.osc_req_prev && !s_ff.ctrl2.ext_osc_request)) begin
            nxt_s.osc_init_done = 1'b0;
            nxt_s.osc_cnt = 13'h0;
        end
        if (s_ff.ctrl2.ext_osc_request && ext_in_use && !s_ff.osc_init_done && ext_rise) begin
            if (s_ff.osc_cnt >= 13'(OSC_INIT_TICKS - 1'b1)) begin
                nxt_s.osc_init_done = 1'b1;
            end else begin
                nxt_s.osc_cnt = 13'(s_ff.osc_cnt + 1'b1);
            end
        end

        // Reference division, period measurement and lock tracking.
        if (ref_rise) begin
            nxt_s.div_cnt = div_tick ? 7'h0 : 7'(s_ff.div_cnt + 1'b1);
        end
        if (div_tick) begin
            nxt_s.fll_period = s_ff.per_cnt;
            nxt_s.per_cnt = 20'h0;
            if (s_ff.lock_cnt >= `CFG_RELOCK_TICKS - 4'h1) begin
                nxt_s.fll_locked = 1'b1;
            end else begin
                nxt_s.lock_cnt = 4'(s_ff.lock_cnt + 1'b1);
            end
        end else if (s_ff.per_cnt != 20'hfffff) begin
            nxt_s.per_cnt = 20'(s_ff.per_cnt + 1'b1);
        end
        nxt_s.refsel_prev = s_ff.ctrl1.ref_select;
        if (s_ff.refsel_prev != s_ff.ctrl1.ref_select) begin
            nxt_s.fll_locked = 1'b0;
            nxt_s.lock_cnt = 4'h0;
            nxt_s.div_cnt = 7'h0;
            nxt_s.per_cnt = 20'h0;
        end

        // Source switch: count ticks of the new clock, then hand over while both are low.
        if (s_ff.sw_target == `CFG_SRC_INT) begin
            tgt_rise = int_rise;
        end else if (s_ff.sw_target == `CFG_SRC_EXT) begin
            tgt_rise = ext_rise;
        end else begin
            tgt_rise = fll_rise;
        end
        case (s_ff.sw_state)
            sw_idle: begin
                if (target != s_ff.active_src) begin
                    nxt_s.sw_target = target;
                    nxt_s.sw_cnt = 4'h0;
                    nxt_s.sw_state = sw_count;
                end
            end
            sw_count: begin
                if (target != s_ff.sw_target) begin
                    nxt_s.sw_state = sw_idle;
                end else if (tgt_rise) begin
                    // A source that never ticks leaves the old clock selected.
                    nxt_s.sw_cnt = 4'(s_ff.sw_cnt + 1'b1);
                    if (s_ff.sw_cnt >= `CFG_SWITCH_TICKS - 4'h1) begin
                        nxt_s.sw_state = sw_handover;
                    end
                end
            end
            sw_handover: begin
                if (target != s_ff.sw_target) begin
                    nxt_s.sw_state = sw_idle;
                end else if (!src_lvl(s_ff.active_src, s_ff) &&
                             !src_lvl(s_ff.sw_target, s_ff)) begin
                    nxt_s.active_src = s_ff.sw_target;
                    nxt_s.sw_state = sw_idle;
                end
            end
            default: begin
                nxt_s.sw_state = sw_idle;
            end
        endcase

        // Outputs; in stop the main, bus and link clocks freeze low.
        if (s_ff.active_src == `CFG_SRC_INT) begin
            main_rise = int_rise;
        end else if (s_ff.active_src == `CFG_SRC_EXT) begin
            main_rise = ext_rise;
        end else begin
            main_rise = fll_rise;
        end
        main_rise = main_rise && !stop_in;
        nxt_s.main_clk = !stop_in && src_lvl(s_ff.active_src, s_ff);
        nxt_s.bus_en = 1'b0;
        if (main_rise) begin
            if (s_ff.bus_cnt >= bus_limit) begin
                nxt_s.bus_en = 1'b1;
                nxt_s.bus_cnt = 3'h0;
            end else begin
                nxt_s.bus_cnt = 3'(s_ff.bus_cnt + 1'b1);
            end
        end
        nxt_s.dbg_clk = fll_run && s_ff.fll_lvl;
        nxt_s.int_out = s_ff.ctrl1.int_ref_enable && int_run && s_ff.int_lvl;
        nxt_s.ext_out = s_ff.ctrl2.ext_ref_enable && ext_in_use && s_ff.ext_s2;
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_ff <= STATE_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign wb_dat_out = s_ff.wb_dat;
    assign wb_ack_out = s_ff.wb_ack;
    assign main_clock_out = s_ff.main_clk;
    assign bus_clk_en_out = s_ff.bus_en;
    assign debug_link_clock_out = s_ff.dbg_clk;
    assign int_ref_clock_out = s_ff.int_out;
    assign ext_ref_clock_out = s_ff.ext_out;

endmodule : fll_clock_mode_controller

/* File: fll_clock_mode_controller_monitor.sv */
// Concurrent checks on the clock mode controller ports, bound to every instance.
`include "fll_clock_cfg.svh"

module fll_clock_mode_controller_monitor (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // System state and clocks
    input wire logic stop_in,
    input wire logic debug_mode_active_in,
    input wire logic ext_ref_in,
    input wire logic main_clock_out,
    input wire logic bus_clk_en_out,
    input wire logic debug_link_clock_out,
    input wire logic int_ref_clock_out,
    input wire logic ext_ref_clock_out
);
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic [7:0] trim_ff;
    logic fine_ff;
    logic wr_ok;

    // Shadow copies follow completed writes so reads can be judged against them.
    assign wr_ok = wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0];

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl1_ff <= `CFG_CTRL1_RESET;
            ctrl2_ff <= `CFG_CTRL2_RESET;
            trim_ff <= `CFG_TRIM_RESET;
            fine_ff <= 1'b0;
        end else if (wr_ok) begin
            if (wb_adr_in == `CFG_OFF_CTRL1)
                ctrl1_ff <= (wb_dat_in[7:6] == 2'h3) ? {2'h0, wb_dat_in[5:0]} : wb_dat_in[7:0];
            if (wb_adr_in == `CFG_OFF_CTRL2)
                ctrl2_ff <= wb_dat_in[7:0];
            if (wb_adr_in == `CFG_OFF_TRIM)
                trim_ff <= wb_dat_in[7:0];
            if (wb_adr_in == `CFG_OFF_STATUS)
                fine_ff <= wb_dat_in[0];
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_read(logic [3:0] a);
        wb_ack_out && wb_cyc_in && wb_stb_in && !wb_we_in && wb_adr_in == a;
    endsequence
    sequence s_stop_held;
        stop_in [*3];
    endsequence

    property p_ack_pulse;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    property p_ack_follows;
        wb_cyc_in && wb_stb_in && !wb_ack_out && !$past(wb_ack_out) |=> wb_ack_out;
    endproperty
    property p_trim_rb;
        s_read(`CFG_OFF_TRIM) |-> wb_dat_out == {24'h0, trim_ff};
    endproperty
    property p_fine_rb;
        s_read(`CFG_OFF_STATUS) |-> wb_dat_out[0] == fine_ff;
    endproperty
    property p_status_rsvd;
        s_read(`CFG_OFF_STATUS) |-> wb_dat_out[31:4] == 28'h0;
    endproperty
    property p_src_rb;
        s_read(`CFG_OFF_CTRL1) |-> wb_dat_out == {24'h0, ctrl1_ff};
    endproperty
    property p_osc_needs_req;
        s_read(`CFG_OFF_STATUS) ##0 wb_dat_out[1] |-> ctrl2_ff[2] || $past(ctrl2_ff[2], 4);
    endproperty
    property p_stop_main;
        s_stop_held |-> !main_clock_out && !bus_clk_en_out && $stable(debug_link_clock_out);
    endproperty
    property p_int_stop;
        s_stop_held ##0 !(ctrl1_ff[1] && ctrl1_ff[0]) |-> $stable(int_ref_clock_out);
    endproperty
    property p_ext_stop;
        s_stop_held ##0 !(ctrl2_ff[1] && ctrl2_ff[0]) |-> $stable(ext_ref_clock_out);
    endproperty

    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_follows: assert property (p_ack_follows) else $error("request not acked next cycle");
    a_trim_rb: assert property (p_trim_rb) else $error("trim readback wrong");
    a_fine_rb: assert property (p_fine_rb) else $error("fine trim readback wrong");
    a_status_rsvd: assert property (p_status_rsvd) else $error("status high bits set");
    a_src_rb: assert property (p_src_rb) else $error("control one readback wrong");
    a_osc_needs_req: assert property (p_osc_needs_req) else $error("done without request");
    a_stop_main: assert property (p_stop_main) else $error("clock moves in stop");
    a_int_stop: assert property (p_int_stop) else $error("internal clock runs in stop");
    a_ext_stop: assert property (p_ext_stop) else $error("external clock runs in stop");

endmodule : fll_clock_mode_controller_monitor

bind fll_clock_mode_controller fll_clock_mode_controller_monitor fll_clock_mode_controller_monitor_inst (
    .ref_clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .stop_in, .debug_mode_active_in, .ext_ref_in,
    .main_clock_out, .bus_clk_en_out, .debug_link_clock_out, .int_ref_clock_out,
    .ext_ref_clock_out
);

/* File: tb_fll_clock.sv */
// Self-checking bench of the clock mode controller.
`include "fll_clock_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk_in = 0, reset_n_in = 0, cyc = 0, stb = 0, we = 0, stop = 0, dbg = 0;
    logic ext = 0, ext_run = 0, ack, main_o, bus_o, link_o, int_o, ext_o;
    logic main_p = 0, link_p = 0, int_p = 0, ext_p = 0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    int failures = 0, checks_done = 0, ediv = 0, d0 = 0;
    int mains = 0, buses = 0, links = 0, ints = 0, exts = 0, dm, db, dl, di, de;

    fll_clock_mode_controller #(.OSC_INIT_TICKS(13'h0004), .INT_HALF_BASE(11'h008))
        fll_clock_mode_controller_inst (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dat_o),
        .wb_ack_out(ack), .stop_in(stop), .debug_mode_active_in(dbg), .ext_ref_in(ext),
        .main_clock_out(main_o), .bus_clk_en_out(bus_o), .debug_link_clock_out(link_o),
        .int_ref_clock_out(int_o), .ext_ref_clock_out(ext_o));

    always #10 ref_clk_in = ~ref_clk_in;

    // The external reference toggles every third cycle, and stands still until it is started.
    always @(posedge ref_clk_in) begin
        if (ext_run) begin
            ediv <= (ediv + 1) % 3;
            if (ediv == 0)
                ext <= ~ext;
        end
    end

    always @(posedge ref_clk_in) begin
        mains += int'(main_o && !main_p);
        buses += int'(bus_o);
        links += int'(link_o != link_p);
        ints += int'(int_o != int_p);
        exts += int'(ext_o != ext_p);
        main_p = main_o;
        link_p = link_o;
        int_p = int_o;
        ext_p = ext_o;
    end

    task final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        // A missing ack is left to the watchdog, which ends the run as a failure.
        do begin
            @(posedge ref_clk_in);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk_in);
    endtask : wb

    task rd(input logic [3:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        check(rdat, {24'h0, exp});
    endtask : rd

    task wait_src(input logic [1:0] s);
        for (int i = 0; i < 60; i++) begin
            wb(1'b0, `CFG_OFF_STATUS, 8'h00);
            if (rdat[3:2] === s)
                break;
        end
        check(rdat[3:2], s);
    endtask : wait_src

    task window(input int len);
        int m, b, l, i, e;
        m = mains;
        b = buses;
        l = links;
        i = ints;
        e = exts;
        repeat (len) @(posedge ref_clk_in);
        dm = mains - m;
        db = buses - b;
        dl = links - l;
        di = ints - i;
        de = exts - e;
    endtask : window

    task t_regs;
        rd(`CFG_OFF_CTRL1, `CFG_CTRL1_RESET);
        rd(`CFG_OFF_CTRL2, `CFG_CTRL2_RESET);
        rd(`CFG_OFF_TRIM, `CFG_TRIM_RESET);
        rd(`CFG_OFF_STATUS, 8'h00);
        rd(4'h2, 8'h00);
        wb(1'b1, `CFG_OFF_TRIM, 8'ha5);
        rd(`CFG_OFF_TRIM, 8'ha5);
        wb(1'b1, `CFG_OFF_TRIM, 8'h00);
        wb(1'b1, `CFG_OFF_STATUS, 8'hf1);
        rd(`CFG_OFF_STATUS, 8'h01);
        wb(1'b1, `CFG_OFF_STATUS, 8'h00);
        $display("test registers done");
    endtask : t_regs

    task t_int;
        wb(1'b1, `CFG_OFF_CTRL1, 8'h46);
        rd(`CFG_OFF_STATUS, 8'h00);
        wait_src(`CFG_SRC_INT);
        wb(1'b1, `CFG_OFF_CTRL2, 8'h48);
        // The link clock may still show its last toggle two edges after the write lands.
        repeat (2) @(posedge ref_clk_in);
        window(300);
        check(dl, 0);
        check(dm > 0, 1'b1);
        d0 = di;
        wb(1'b1, `CFG_OFF_TRIM, 8'h04);
        window(300);
        check(di < d0, 1'b1);
        wb(1'b1, `CFG_OFF_TRIM, 8'h00);
        dbg <= 1'b1;
        window(300);
        check(dl > 0, 1'b1);
        dbg <= 1'b0;
        wb(1'b1, `CFG_OFF_CTRL2, 8'h40);
        wb(1'b1, `CFG_OFF_CTRL1, 8'hc4);
        rd(`CFG_OFF_CTRL1, 8'h04);
        wait_src(`CFG_SRC_FLL);
        $display("test internal switch done");
    endtask : t_int

    task t_ext;
        wb(1'b1, `CFG_OFF_CTRL1, 8'h82);
        window(300);
        rd(`CFG_OFF_STATUS, 8'h00);
        ext_run <= 1'b1;
        wait_src(`CFG_SRC_EXT);
        wb(1'b1, `CFG_OFF_CTRL2, 8'h46);
        for (int i = 0; i < 30 && rdat[1] !== 1'b1; i++)
            wb(1'b0, `CFG_OFF_STATUS, 8'h00);
        check(rdat[1], 1'b1);
        wb(1'b1, `CFG_OFF_CTRL2, 8'h42);
        wb(1'b0, `CFG_OFF_STATUS, 8'h00);
        rd(`CFG_OFF_STATUS, 8'h08);
        wb(1'b1, `CFG_OFF_CTRL2, 8'h4a);
        repeat (2) @(posedge ref_clk_in);
        window(120);
        check(dl, 0);
        check(dm > 0, 1'b1);
        wb(1'b1, `CFG_OFF_CTRL2, 8'h42);
        wb(1'b1, `CFG_OFF_CTRL1, 8'h02);
        wait_src(`CFG_SRC_FLL);
        window(120);
        check(dl > 0, 1'b1);
        $display("test external switch done");
    endtask : t_ext

    task t_stop(input logic [7:0] c1, input logic [7:0] c2, input logic run);
        wb(1'b1, `CFG_OFF_CTRL1, c1);
        wb(1'b1, `CFG_OFF_CTRL2, c2);
        stop <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        window(120);
        stop <= 1'b0;
        check(dm, 0);
        check(di > 0, run);
        check(de > 0, run);
        $display("test stop done");
    endtask : t_stop

    task t_busdiv;
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `CFG_OFF_CTRL2, {c[1:0], 6'h02});
            window(480);
            check((db << c) <= dm + (1 << c) && dm <= (db << c) + (1 << c), 1'b1);
        end
        $display("test bus divider done");
    endtask : t_busdiv

    initial begin
        repeat (60000) @(posedge ref_clk_in);
        failures++;
        final_report;
    end

    initial begin
        repeat (5) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        @(posedge ref_clk_in);
        t_regs;
        t_int;
        t_ext;
        t_stop(8'h83, 8'h43, 1'b1);
        t_stop(8'h82, 8'h42, 1'b0);
        t_busdiv;
        final_report;
    end

endmodule : testbench
